// ==== core/psm_datapath.v ====
/*
 packed 64-bit simd integer execution datapath: max/min, high multiply,
 sum of absolute differences, saturating add/subtract, wrapping subtract, compare.
 assumes the issuing core supplies operands from a register or a memory load
 and writes o_result back; a request taken on one edge shows its result
 and o_valid on the next edge, two edges from drive to answer.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psm_defines.vh"

module psm_datapath
(
    input wire i_clock,
    input wire i_reset,
    input wire i_valid,
    input wire [3:0] i_op,
    input wire i_cmpgt,
    input wire [63:0] i_a,
    input wire [63:0] i_b,
    output reg o_valid,
    output reg [63:0] o_result
);

    localparam MODE_ALU = 2'h0;
    localparam MODE_MUL = 2'h1;
    localparam MODE_SAD = 2'h2;

    // signed word compare helpers
    function [15:0] smax16;
        input [15:0] x;
        input [15:0] y;
        begin
            smax16 = ($signed(x) > $signed(y)) ? x : y;
        end
    endfunction

    function [15:0] smin16;
        input [15:0] x;
        input [15:0] y;
        begin
            smin16 = ($signed(x) < $signed(y)) ? x : y;
        end
    endfunction

    // byte lane add/subtract with signed or unsigned clamp
    function [7:0] sat8;
        input [7:0] x;
        input [7:0] y;
        input sub;
        input sgn;
        reg [9:0] r;
        begin
            r = sub ? ({{2{sgn & x[7]}}, x} - {{2{sgn & y[7]}}, y})
                    : ({{2{sgn & x[7]}}, x} + {{2{sgn & y[7]}}, y});
            if (sgn)
            begin
                // signed in, signed clamp; never clamps signed to unsigned
                if (r[9] && !r[7]) sat8 = 8'h80;
                else if (!r[9] && r[7]) sat8 = 8'h7f;
                else sat8 = r[7:0];
            end
            else
            begin
                if (r[9]) sat8 = 8'h00;
                else if (r[8]) sat8 = 8'hff;
                else sat8 = r[7:0];
            end
        end
    endfunction

    // word lane add/subtract with signed or unsigned clamp
    function [15:0] sat16;
        input [15:0] x;
        input [15:0] y;
        input sub;
        input sgn;
        reg [17:0] r;
        begin
            r = sub ? ({{2{sgn & x[15]}}, x} - {{2{sgn & y[15]}}, y})
                    : ({{2{sgn & x[15]}}, x} + {{2{sgn & y[15]}}, y});
            if (sgn)
            begin
                if (r[17] && !r[15]) sat16 = 16'h8000;
                else if (!r[17] && r[15]) sat16 = 16'h7fff;
                else sat16 = r[15:0];
            end
            else
            begin
                if (r[17]) sat16 = 16'h0000;
                else if (r[16]) sat16 = 16'hffff;
                else sat16 = r[15:0];
            end
        end
    endfunction

    wire [15:0] sad_sum;
    wire [63:0] mul_hi;
    reg mul_signed;
    reg [63:0] alu_d;
    reg [63:0] alu_q;
    reg [1:0] mode_d;
    reg [1:0] mode_q;
    reg valid_q;
    integer i;

    // multiply and sad sit in their own registered units; results align at stage one
    psm_mulhi_unit u_mulhi
    (
        .i_clock(i_clock),
        .i_signed(mul_signed),
        .i_a(i_a),
        .i_b(i_b),
        .o_hi(mul_hi)
    );

    psm_sad_unit u_sad
    (
        .i_clock(i_clock),
        .i_a(i_a),
        .i_b(i_b),
        .o_sum(sad_sum)
    );

    // operation select for the simple lane operations
    always @*
    begin
        alu_d = 64'h0000000000000000;
        mode_d = MODE_ALU;
        mul_signed = (i_op == `PSM_OP_MULHSW);
        if (i_cmpgt)
        begin
            // compare is a side entry so the op space stays full
            for (i = 0; i < 4; i = i + 1)
            begin
                alu_d[16*i +: 16] = ($signed(i_a[16*i +: 16]) > $signed(i_b[16*i +: 16]))
                                    ? 16'hffff : 16'h0000;
            end
        end
        else
        begin
            case (i_op)
                `PSM_OP_MAXSW:
                begin
                    for (i = 0; i < 4; i = i + 1)
                    begin
                        alu_d[16*i +: 16] = smax16(i_a[16*i +: 16], i_b[16*i +: 16]);
                    end
                end
                `PSM_OP_MINSW:
                begin
                    for (i = 0; i < 4; i = i + 1)
                    begin
                        alu_d[16*i +: 16] = smin16(i_a[16*i +: 16], i_b[16*i +: 16]);
                    end
                end
                `PSM_OP_MAXUB:
                begin
                    for (i = 0; i < 8; i = i + 1)
                    begin
                        alu_d[8*i +: 8] = (i_a[8*i +: 8] > i_b[8*i +: 8])
                                          ? i_a[8*i +: 8] : i_b[8*i +: 8];
                    end
                end
                `PSM_OP_MINUB:
                begin
                    for (i = 0; i < 8; i = i + 1)
                    begin
                        alu_d[8*i +: 8] = (i_a[8*i +: 8] < i_b[8*i +: 8])
                                          ? i_a[8*i +: 8] : i_b[8*i +: 8];
                    end
                end
                // wide units have already registered their results; only the select travels
                `PSM_OP_MULHUW, `PSM_OP_MULHSW:
                    mode_d = MODE_MUL;
                `PSM_OP_SADBW:
                    mode_d = MODE_SAD;
                // saturating byte lanes
                `PSM_OP_ADDSB:
                begin
                    for (i = 0; i < 8; i = i + 1)
                    begin
                        alu_d[8*i +: 8] = sat8(i_a[8*i +: 8], i_b[8*i +: 8], 1'b0, 1'b1);
                    end
                end
                `PSM_OP_ADDUSB:
                begin
                    for (i = 0; i < 8; i = i + 1)
                    begin
                        alu_d[8*i +: 8] = sat8(i_a[8*i +: 8], i_b[8*i +: 8], 1'b0, 1'b0);
                    end
                end
                `PSM_OP_SUBSB:
                begin
                    for (i = 0; i < 8; i = i + 1)
                    begin
                        alu_d[8*i +: 8] = sat8(i_a[8*i +: 8], i_b[8*i +: 8], 1'b1, 1'b1);
                    end
                end
                `PSM_OP_SUBUSB:
                begin
                    for (i = 0; i < 8; i = i + 1)
                    begin
                        alu_d[8*i +: 8] = sat8(i_a[8*i +: 8], i_b[8*i +: 8], 1'b1, 1'b0);
                    end
                end
                // saturating word lanes, then the wrapping word subtract
                `PSM_OP_ADDSW:
                begin
                    for (i = 0; i < 4; i = i + 1)
                    begin
                        alu_d[16*i +: 16] = sat16(i_a[16*i +: 16], i_b[16*i +: 16], 1'b0, 1'b1);
                    end
                end
                `PSM_OP_ADDUSW:
                begin
                    for (i = 0; i < 4; i = i + 1)
                    begin
                        alu_d[16*i +: 16] = sat16(i_a[16*i +: 16], i_b[16*i +: 16], 1'b0, 1'b0);
                    end
                end
                `PSM_OP_SUBSW:
                begin
                    for (i = 0; i < 4; i = i + 1)
                    begin
                        alu_d[16*i +: 16] = sat16(i_a[16*i +: 16], i_b[16*i +: 16], 1'b1, 1'b1);
                    end
                end
                `PSM_OP_SUBUSW:
                begin
                    for (i = 0; i < 4; i = i + 1)
                    begin
                        alu_d[16*i +: 16] = sat16(i_a[16*i +: 16], i_b[16*i +: 16], 1'b1, 1'b0);
                    end
                end
                `PSM_OP_SUBW:
                begin
                    // plain wrap: 0 - 8000 hex stays 8000 hex, no clamp
                    for (i = 0; i < 4; i = i + 1)
                    begin
                        alu_d[16*i +: 16] = i_a[16*i +: 16] - i_b[16*i +: 16];
                    end
                end
                default:
                    alu_d = 64'h0000000000000000;
            endcase
        end
    end

    // stage one: hold simple result and which unit to take
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            alu_q <= 64'h0000000000000000;
            mode_q <= MODE_ALU;
            valid_q <= 1'b0;
        end
        else
        begin
            alu_q <= alu_d;
            mode_q <= mode_d;
            valid_q <= i_valid;
        end
    end

    // stage two: output straight from flops; costs a cycle but keeps muxing off the port
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            o_result <= 64'h0000000000000000;
            o_valid <= 1'b0;
        end
        else
        begin
            o_valid <= valid_q;
            case (mode_q)
                MODE_MUL: o_result <= mul_hi;
                MODE_SAD: o_result <= {48'h000000000000, sad_sum};
                default: o_result <= alu_q;
            endcase
        end
    end

endmodule // psm_datapath

`default_nettype wire

// ==== core/psm_defines.vh ====
/*
 packed simd execution datapath: operation codes, op width, data width and lane counts.
 assumes inclusion by the datapath files by bare name.
*/
`ifndef PSM_DEFINES_VH
`define PSM_DEFINES_VH

`define PSM_OP_WIDTH 4
`define PSM_OP_MAXSW 4'h0
`define PSM_OP_MINSW 4'h1
`define PSM_OP_MAXUB 4'h2
`define PSM_OP_MINUB 4'h3
`define PSM_OP_MULHUW 4'h4
`define PSM_OP_MULHSW 4'h5
`define PSM_OP_SADBW 4'h6
`define PSM_OP_ADDSB 4'h7
`define PSM_OP_ADDSW 4'h8
`define PSM_OP_ADDUSB 4'h9
`define PSM_OP_ADDUSW 4'ha
`define PSM_OP_SUBSB 4'hb
`define PSM_OP_SUBSW 4'hc
`define PSM_OP_SUBUSB 4'hd
`define PSM_OP_SUBUSW 4'he
`define PSM_OP_SUBW 4'hf

`define PSM_DATA_WIDTH 64
`define PSM_WORD_LANES 4
`define PSM_BYTE_LANES 8

`endif

// ==== core/psm_sad_unit.v ====
/*
 sum of absolute byte differences over eight unsigned byte lanes, registered.
 assumes operands held stable by the caller for the cycle they are sampled.
*/
`timescale 1ns/10ps
`default_nettype none

module psm_sad_unit
(
    input wire i_clock,
    input wire [63:0] i_a,
    input wire [63:0] i_b,
    output reg [15:0] o_sum
);

    // absolute difference of one unsigned byte pair
    function [7:0] absdiff;
        input [7:0] x;
        input [7:0] y;
        begin
            absdiff = (x > y) ? (x - y) : (y - x);
        end
    endfunction

    reg [15:0] acc;
    integer i;

    // adder tree folded into a loop; eight bytes of 255 fit in 11 bits
    always @*
    begin
        acc = 16'h0000;
        for (i = 0; i < 8; i = i + 1)
        begin
            acc = acc + {8'h00, absdiff(i_a[8*i +: 8], i_b[8*i +: 8])};
        end
    end

    always @(posedge i_clock)
    begin
        o_sum <= acc;
    end

endmodule // psm_sad_unit

`default_nettype wire

// ==== core/psm_mulhi_unit.v ====
/*
 four-lane 16x16 multiply keeping the upper half of each product, registered.
 assumes the signed select is steady with the operands.
*/
`timescale 1ns/10ps
`default_nettype none

module psm_mulhi_unit
(
    input wire i_clock,
    input wire i_signed,
    input wire [63:0] i_a,
    input wire [63:0] i_b,
    output reg [63:0] o_hi
);

    // one lane: extend both factors by one bit so one multiplier serves both forms
    function [15:0] mulhi;
        input [15:0] x;
        input [15:0] y;
        input s;
        reg signed [16:0] xe;
        reg signed [16:0] ye;
        reg signed [33:0] p;
        begin
            xe = {s & x[15], x};
            ye = {s & y[15], y};
            p = xe * ye;
            mulhi = p[31:16];
        end
    endfunction

    reg [63:0] hi;
    integer i;

    always @*
    begin
        hi = 64'h0000000000000000;
        for (i = 0; i < 4; i = i + 1)
        begin
            hi[16*i +: 16] = mulhi(i_a[16*i +: 16], i_b[16*i +: 16], i_signed);
        end
    end

    always @(posedge i_clock)
    begin
        o_hi <= hi;
    end

endmodule // psm_mulhi_unit

`default_nettype wire

// ==== verif/psm_datapath_monitor.sv ====
/*
 checker for the packed simd datapath: lane results against the request two edges back.
 assumes it is bound to psm_datapath and that requests are held off during reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psm_defines.vh"

module psm_datapath_monitor
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_valid,
    input wire logic [3:0] i_op,
    input wire logic i_cmpgt,
    input wire logic [63:0] i_a,
    input wire logic [63:0] i_b,
    input wire logic o_valid,
    input wire logic [63:0] o_result
);
    logic [63:0] a1_q, a2_q, b1_q, b2_q;
    logic [3:0] op1_q, op2_q;
    logic c1_q, c2_q, v1_q, v2_q;
    // request copy two stages deep; valid copies drop in reset since requests are lost then
    always @(posedge i_clock)
    begin
        {a1_q, b1_q, op1_q, c1_q} <= {i_a, i_b, i_op, i_cmpgt};
        {a2_q, b2_q, op2_q, c2_q} <= {a1_q, b1_q, op1_q, c1_q};
        v1_q <= i_valid && !i_reset;
        v2_q <= v1_q && !i_reset;
    end
    // low lanes only, apart from the clear upper words of the difference sum; the bench covers the rest
    wire logic [15:0] w_hot = (v2_q && !c2_q) ? (16'h1 << op2_q) : 16'h0;
    wire logic signed [15:0] wa = a2_q[15:0], wb = b2_q[15:0], wr = o_result[15:0];
    wire logic [7:0] ya = a2_q[7:0], yb = b2_q[7:0], yr = o_result[7:0];
    wire logic [31:0] w_pu = a2_q[15:0] * b2_q[15:0];
    wire logic signed [31:0] w_ps = wa * wb;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    a_valid_latency: assert property (o_valid == v2_q)
        else $error("result strobe not two cycles after request");
    a_max_sw: assert property (w_hot[`PSM_OP_MAXSW] |-> wr == (wa > wb ? wa : wb))
        else $error("signed word max wrong");
    a_min_sw: assert property (w_hot[`PSM_OP_MINSW] |-> wr == (wa < wb ? wa : wb))
        else $error("signed word min wrong");
    a_max_ub: assert property (w_hot[`PSM_OP_MAXUB] |-> yr == (ya > yb ? ya : yb))
        else $error("unsigned byte max wrong");
    a_min_ub: assert property (w_hot[`PSM_OP_MINUB] |-> yr == (ya < yb ? ya : yb))
        else $error("unsigned byte min wrong");
    a_mulhi_unsigned: assert property (w_hot[`PSM_OP_MULHUW] |-> wr == w_pu[31:16])
        else $error("unsigned high multiply wrong");
    a_mulhi_signed: assert property (w_hot[`PSM_OP_MULHSW] |-> wr == w_ps[31:16])
        else $error("signed high multiply wrong");
    a_sad_upper: assert property (w_hot[`PSM_OP_SADBW] |-> o_result[63:16] == 48'h0)
        else $error("difference sum upper words not clear");
    a_wrap_sub: assert property (w_hot[`PSM_OP_SUBW] |-> o_result[15:0] == a2_q[15:0] - b2_q[15:0])
        else $error("wrapping word subtract wrong");
    a_cmp_gt: assert property (v2_q && c2_q |-> wr == (wa > wb ? 16'hffff : 16'h0))
        else $error("signed greater-than mask wrong");
    a_unsat_floor: assert property (w_hot[`PSM_OP_SUBUSB] |-> yr == (ya > yb ? ya - yb : 8'h0))
        else $error("unsigned byte subtract not floored");
endmodule // psm_datapath_monitor

bind psm_datapath psm_datapath_monitor u_mon (.i_clock(i_clock), .i_reset(i_reset), .i_valid(i_valid),
    .i_op(i_op), .i_cmpgt(i_cmpgt), .i_a(i_a), .i_b(i_b), .o_valid(o_valid), .o_result(o_result));
`default_nettype wire

// ==== verif/psm_core_model.sv ====
/*
 issuing core model: operands from a register or one memory word, result written back.
 assumes it is steered just after rising edges.
*/
`timescale 1ns/10ps
`default_nettype none

module psm_core_model
(
    input wire logic i_clock,
    input wire logic i_go,
    input wire logic [63:0] i_a,
    input wire logic [63:0] i_b,
    input wire logic i_use_mem,
    input wire logic i_use_dst,
    input wire logic i_res_valid,
    input wire logic [63:0] i_result,
    output logic o_valid,
    output logic [63:0] o_a,
    output logic [63:0] o_b,
    output logic [63:0] o_dst
);
    localparam [63:0] MEM_WORD = 64'h8000_8000_8000_8000;
    logic [63:0] dst_q = 64'h0;
    wire logic [63:0] w_a = i_use_dst ? dst_q : i_a;
    wire logic [63:0] w_b = i_use_mem ? MEM_WORD : i_b;
    // idle operands flip so the datapath cannot lean on stale values
    assign o_valid = i_go;
    assign o_a = i_go ? w_a : ~w_a;
    assign o_b = i_go ? w_b : ~w_b;
    assign o_dst = dst_q;
    // destination register write-back
    always @(posedge i_clock)
    begin
        if (i_res_valid)
            dst_q <= i_result;
    end
endmodule // psm_core_model
`default_nettype wire

// ==== verif/psm_datapath_bench.sv ====
/*
 self-checking bench for the packed simd datapath driven through the core model.
 assumes a request taken on one edge shows its result right after the next edge.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psm_defines.vh"

module psm_datapath_bench;
    localparam [63:0] A = 64'h8000_7fff_0005_fffe;
    localparam [63:0] B = 64'h7fff_8000_0003_0002;
    logic clock = 1'b0, reset = 1'b1, go = 1'b0, cmp = 1'b0, use_mem = 1'b0, use_dst = 1'b0;
    logic [3:0] op = 4'h0;
    logic [63:0] a = 64'h0, b = 64'h0;
    wire logic v_in, o_valid;
    wire logic [63:0] a_in, b_in, o_result, dst;
    integer fails = 0, num_checks = 0;

    psm_core_model u_core (.i_clock(clock), .i_go(go), .i_a(a), .i_b(b), .i_use_mem(use_mem),
        .i_use_dst(use_dst), .i_res_valid(o_valid), .i_result(o_result), .o_valid(v_in), .o_a(a_in),
        .o_b(b_in), .o_dst(dst));
    psm_datapath uut (.i_clock(clock), .i_reset(reset), .i_valid(v_in), .i_op(op), .i_cmpgt(cmp),
        .i_a(a_in), .i_b(b_in), .o_valid(o_valid), .o_result(o_result));

    // 50 MHz clock
    always #10 clock = ~clock;

    task summarize;
        begin
            if (fails == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task chk(input string n, input [63:0] e, input [63:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e)
            begin
                fails = fails + 1;
                $display("BAD %s expected %h seen %h", n, e, g);
            end
        end
    endtask

    task drv(input [3:0] o, input c, input [63:0] x, input [63:0] y, input m, input d);
        begin
            go = 1'b1;
            op = o;
            cmp = c;
            a = x;
            b = y;
            use_mem = m;
            use_dst = d;
        end
    endtask

    // one request, result checked one edge after it is taken, strobe gone one later
    task run(input [3:0] o, input c, input [63:0] x, input [63:0] y, input m, input d, input [63:0] e);
        begin
            drv(o, c, x, y, m, d);
            @(posedge clock) #1 go = 1'b0;
            @(posedge clock) #1 chk("valid", 64'h1, {63'h0, o_valid});
            chk("result", e, o_result);
            @(posedge clock) #1 chk("valid_drop", 64'h0, {63'h0, o_valid});
        end
    endtask

    task t_minmax;
        begin
            run(`PSM_OP_MAXSW, 1'b0, A, B, 1'b0, 1'b0, 64'h7fff_7fff_0005_0002);
            run(`PSM_OP_MINSW, 1'b0, A, B, 1'b0, 1'b0, 64'h8000_8000_0003_fffe);
            run(`PSM_OP_MAXUB, 1'b0, A, B, 1'b0, 1'b0, 64'h80ff_80ff_0005_fffe);
            run(`PSM_OP_MINUB, 1'b0, A, B, 1'b0, 1'b0, 64'h7f00_7f00_0003_0002);
        end
    endtask

    task t_mul_sad;
        begin
            run(`PSM_OP_MULHUW, 1'b0, A, B, 1'b0, 1'b0, 64'h3fff_3fff_0000_0001);
            run(`PSM_OP_MULHSW, 1'b0, A, B, 1'b0, 1'b0, 64'hc000_c000_0000_ffff);
            run(`PSM_OP_SADBW, 1'b0, A, B, 1'b0, 1'b0, 64'h0000_0000_0000_03fd);
        end
    endtask

    task t_sat;
        begin
            run(`PSM_OP_ADDSB, 1'b0, A, A, 1'b0, 1'b0, 64'h8000_7ffe_000a_fefc);
            run(`PSM_OP_ADDSW, 1'b0, A, A, 1'b0, 1'b0, 64'h8000_7fff_000a_fffc);
            run(`PSM_OP_ADDUSB, 1'b0, A, A, 1'b0, 1'b0, 64'hff00_feff_000a_ffff);
            run(`PSM_OP_ADDUSW, 1'b0, A, A, 1'b0, 1'b0, 64'hffff_fffe_000a_ffff);
            run(`PSM_OP_SUBSB, 1'b0, A, B, 1'b0, 1'b0, 64'h8001_7fff_0002_fffc);
            run(`PSM_OP_SUBSW, 1'b0, A, B, 1'b0, 1'b0, 64'h8000_7fff_0002_fffc);
            run(`PSM_OP_SUBUSB, 1'b0, A, B, 1'b0, 1'b0, 64'h0100_00ff_0002_fffc);
            run(`PSM_OP_SUBUSW, 1'b0, A, B, 1'b0, 1'b0, 64'h0001_0000_0002_fffc);
        end
    endtask

    // negate then max against the original gives magnitudes, 8000 stays 8000
    task t_wrap;
        begin
            run(`PSM_OP_SUBW, 1'b0, A, B, 1'b0, 1'b0, 64'h0001_ffff_0002_fffc);
            run(`PSM_OP_SUBW, 1'b0, 64'h0, 64'h8000_0001_7fff_ffff, 1'b0, 1'b0, 64'h8000_ffff_8001_0001);
            chk("dst_writeback", 64'h8000_ffff_8001_0001, dst);
            run(`PSM_OP_MAXSW, 1'b0, A, 64'h8000_0001_7fff_ffff, 1'b0, 1'b1, 64'h8000_0001_7fff_0001);
            run(`PSM_OP_SUBW, 1'b0, A, B, 1'b1, 1'b0, 64'h0000_ffff_8005_7ffe);
        end
    endtask

    // three requests back to back, compare overriding the opcode on the last
    task t_pipe;
        begin
            drv(`PSM_OP_MAXSW, 1'b0, A, B, 1'b0, 1'b0);
            @(posedge clock) #1 drv(`PSM_OP_MINUB, 1'b0, A, B, 1'b0, 1'b0);
            @(posedge clock) #1 drv(`PSM_OP_SUBW, 1'b1, A, B, 1'b0, 1'b0);
            chk("pipe_max", 64'h7fff_7fff_0005_0002, o_result);
            @(posedge clock) #1 go = 1'b0;
            chk("pipe_min", 64'h7f00_7f00_0003_0002, o_result);
            @(posedge clock) #1 chk("pipe_cmp", 64'h0000_ffff_ffff_0000, o_result);
            chk("pipe_valid", 64'h1, {63'h0, o_valid});
        end
    endtask

    // watchdog at 2000 cycles, well beyond the 67 cycles the tests take
    initial
    begin
        #(20 * 2000);
        fails = fails + 1;
        summarize;
    end

    initial
    begin
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        chk("reset_valid", 64'h0, {63'h0, o_valid});
        chk("reset_result", 64'h0, o_result);
        t_minmax;
        t_mul_sad;
        t_sat;
        t_wrap;
        t_pipe;
        summarize;
    end
endmodule // psm_datapath_bench
`default_nettype wire
